// file: logic/eqf_defs.vh
`ifndef EQF_DEFS_VH
`define EQF_DEFS_VH

// ----------------------------------------
// Register map, word addresses
// ----------------------------------------
`define EQF_ADDR_W          12
`define EQF_OFS_A_TAP6      12'h423
`define EQF_OFS_A_TAP7      12'h425
`define EQF_OFS_A_TAP8      12'h427
`define EQF_OFS_A_TAP9      12'h429
`define EQF_OFS_B_TAP1      12'h448

// ----------------------------------------
// Register layout and reset
// ----------------------------------------
`define EQF_REG_W           16
`define EQF_COEFF_MSB       11
`define EQF_COEFF_W         12
`define EQF_RSVD_MSB        15
`define EQF_RSVD_LSB        12
`define EQF_REG_RST         16'h0000
`define EQF_RD_IDLE         16'h0000

// ----------------------------------------
// Filter shape
// ----------------------------------------
`define EQF_TAPS            9
`define EQF_CENTRE_W        18
`define EQF_SAMPLE_W        12
`define EQF_PROD_W          30
`define EQF_ACC_W           34
`define EQF_CVEC_W          162

`endif

// file: logic/eqf_fir9.v
`include "eqf_defs.vh"

// Nine-tap direct-form FIR; tap 1 weights the newest sample.
// All weights arrive as 18-bit signed values, narrow taps pre-extended.
module eqf_fir9 (
	input  wire                         clk,
	input  wire                         rst_n,
	input  wire [`EQF_SAMPLE_W-1:0]     sample_in,
	input  wire                         sample_valid,
	input  wire [`EQF_CVEC_W-1:0]       coeff_vec,
	output reg  [`EQF_ACC_W-1:0]        filt_out,
	output reg                          filt_valid
);

	// ----------------------------------------
	// Sample history
	// ----------------------------------------
	reg        [`EQF_SAMPLE_W-1:0]      hist_reg [0:`EQF_TAPS-2];
	reg        [`EQF_SAMPLE_W-1:0]      win [0:`EQF_TAPS-1];
	reg signed [`EQF_SAMPLE_W-1:0]      s_val;
	reg signed [`EQF_CENTRE_W-1:0]      c_val;
	reg signed [`EQF_PROD_W-1:0]        prod;
	reg        [`EQF_ACC_W-1:0]         acc_next;
	integer                             i;
	integer                             j;
	integer                             k;

	// Window of the nine most recent samples, newest first
	always @* begin
		win[0] = sample_in;
		for (i = 1; i < `EQF_TAPS; i = i + 1) begin
			win[i] = hist_reg[i-1];
		end
	end

	// Multiply-accumulate against weights in force this cycle
	always @* begin
		acc_next = {`EQF_ACC_W{1'b0}};
		s_val = {`EQF_SAMPLE_W{1'b0}};
		c_val = {`EQF_CENTRE_W{1'b0}};
		prod = {`EQF_PROD_W{1'b0}};
		for (j = 0; j < `EQF_TAPS; j = j + 1) begin
			s_val = win[j];
			c_val = coeff_vec[j*`EQF_CENTRE_W +: `EQF_CENTRE_W];
			prod = s_val * c_val;
			acc_next = acc_next + {{(`EQF_ACC_W-`EQF_PROD_W){prod[`EQF_PROD_W-1]}}, prod};
		end
	end

	// Shift on each accepted sample; output one cycle later
	always @(posedge clk) begin
		if (!rst_n) begin
			for (k = 0; k < `EQF_TAPS-1; k = k + 1) begin
				hist_reg[k] <= {`EQF_SAMPLE_W{1'b0}};
			end
			filt_out <= {`EQF_ACC_W{1'b0}};
			filt_valid <= 1'b0;
		end else begin
			filt_valid <= sample_valid;
			if (sample_valid) begin
				for (k = 0; k < `EQF_TAPS-1; k = k + 1) begin
					hist_reg[k] <= win[k];
				end
				filt_out <= acc_next;
			end
		end
	end

endmodule

// file: logic/eqf_coeff_bank.v
// Implementation choice: the strobed register port.
`include "eqf_defs.vh"

// Behaviour
// - 12-bit signed weight, reserved top, resets zero
// - 0x423 weights tap six, A or combined
// - 0x425 weights tap seven, A or combined
// - 0x427 weights tap eight, A or combined
// - 0x429 weights tap nine, A or combined
// - 0x448 weights channel B tap one, dual only
// - Nine taps; centre tap weight is 18 bits

// Holds tap weights six to nine of channel A and tap one of channel B,
// and runs both nine-tap filters against the weights in force each cycle
module eqf_coeff_bank (
	input  wire                         CORE_CLK,
	input  wire                         RST_N,
	input  wire [`EQF_ADDR_W-1:0]       ADDR,
	input  wire [`EQF_REG_W-1:0]        WR_DATA,
	input  wire                         WR_EN,
	input  wire                         RD_EN,
	output wire [`EQF_REG_W-1:0]        RD_DATA,
	input  wire                         SINGLE_CHAN_MODE,
	input  wire [4*`EQF_COEFF_W-1:0]    A_TAPS_1_4_W,
	input  wire [`EQF_CENTRE_W-1:0]     A_CENTRE_W,
	input  wire [3*`EQF_COEFF_W-1:0]    B_TAPS_2_4_W,
	input  wire [`EQF_CENTRE_W-1:0]     B_CENTRE_W,
	input  wire [4*`EQF_COEFF_W-1:0]    B_TAPS_6_9_W,
	input  wire [`EQF_SAMPLE_W-1:0]     SAMPLE_A_IN,
	input  wire                         SAMPLE_A_VALID,
	input  wire [`EQF_SAMPLE_W-1:0]     SAMPLE_B_IN,
	input  wire                         SAMPLE_B_VALID,
	output wire [`EQF_ACC_W-1:0]        FILT_A_OUT,
	output wire                         FILT_A_VALID,
	output wire [`EQF_ACC_W-1:0]        FILT_B_OUT,
	output wire                         FILT_B_VALID
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Widen a 12-bit weight to the centre-tap width, keeping its sign;
	// the reserved bits above the weight are dropped here and nowhere else
	function [`EQF_CENTRE_W-1:0] sext_w;
		input [`EQF_REG_W-1:0] r;
		begin
			sext_w = {{(`EQF_CENTRE_W-`EQF_COEFF_W){r[`EQF_COEFF_MSB]}}, r[`EQF_COEFF_MSB:0]};
		end
	endfunction

	// One-hot register select; shared by the write and read paths so the two
	// can never disagree about which word an address names
	function [4:0] reg_sel;
		input [`EQF_ADDR_W-1:0] a;
		begin
			reg_sel = 5'h00;
			case (a)
				`EQF_OFS_A_TAP6: reg_sel = 5'h01;
				`EQF_OFS_A_TAP7: reg_sel = 5'h02;
				`EQF_OFS_A_TAP8: reg_sel = 5'h04;
				`EQF_OFS_A_TAP9: reg_sel = 5'h08;
				`EQF_OFS_B_TAP1: reg_sel = 5'h10;
				default:         reg_sel = 5'h00;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	reg  [`EQF_REG_W-1:0]               chan_a_tap6_weight_reg;
	reg  [`EQF_REG_W-1:0]               chan_a_tap7_weight_reg;
	reg  [`EQF_REG_W-1:0]               chan_a_tap8_weight_reg;
	reg  [`EQF_REG_W-1:0]               chan_a_tap9_weight_reg;
	reg  [`EQF_REG_W-1:0]               chan_b_tap1_weight_reg;
	reg  [`EQF_REG_W-1:0]               rd_data_reg;
	reg  [`EQF_REG_W-1:0]               rd_data_next;
	reg                                 dual_mode_reg;
	wire [`EQF_CVEC_W-1:0]              coeff_a;
	wire [`EQF_CVEC_W-1:0]              coeff_b;
	wire                                b_valid_gated;
	wire [4:0]                          addr_sel;
	wire [4:0]                          wr_sel;

	// Per-tap weights of channel A, all at the centre-tap width
	wire [`EQF_CENTRE_W-1:0]            a_tap1_w;
	wire [`EQF_CENTRE_W-1:0]            a_tap2_w;
	wire [`EQF_CENTRE_W-1:0]            a_tap3_w;
	wire [`EQF_CENTRE_W-1:0]            a_tap4_w;
	wire [`EQF_CENTRE_W-1:0]            a_tap5_w;
	wire [`EQF_CENTRE_W-1:0]            a_tap6_w;
	wire [`EQF_CENTRE_W-1:0]            a_tap7_w;
	wire [`EQF_CENTRE_W-1:0]            a_tap8_w;
	wire [`EQF_CENTRE_W-1:0]            a_tap9_w;

	// Per-tap weights of channel B, all at the centre-tap width
	wire [`EQF_CENTRE_W-1:0]            b_tap1_w;
	wire [`EQF_CENTRE_W-1:0]            b_tap2_w;
	wire [`EQF_CENTRE_W-1:0]            b_tap3_w;
	wire [`EQF_CENTRE_W-1:0]            b_tap4_w;
	wire [`EQF_CENTRE_W-1:0]            b_tap5_w;
	wire [`EQF_CENTRE_W-1:0]            b_tap6_w;
	wire [`EQF_CENTRE_W-1:0]            b_tap7_w;
	wire [`EQF_CENTRE_W-1:0]            b_tap8_w;
	wire [`EQF_CENTRE_W-1:0]            b_tap9_w;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------

	// Write select is qualified by the strobe here, once, for all five registers
	assign addr_sel = reg_sel(ADDR);
	assign wr_sel = WR_EN ? addr_sel : 5'h00;

	// ----------------------------------------
	// Write port, one process per register
	// ----------------------------------------

	// Bits 15:12 are stored as written because the whole word is read/write;
	// only bits 11:0 ever reach a filter. Unmapped writes select nothing.

	// Sixth tap of A, or of the combined filter in single-channel mode
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			chan_a_tap6_weight_reg <= `EQF_REG_RST;
		end else if (wr_sel[0]) begin
			chan_a_tap6_weight_reg <= WR_DATA;
		end
	end

	// Seventh tap of A, or of the combined filter
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			chan_a_tap7_weight_reg <= `EQF_REG_RST;
		end else if (wr_sel[1]) begin
			chan_a_tap7_weight_reg <= WR_DATA;
		end
	end

	// Eighth tap of A, or of the combined filter
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			chan_a_tap8_weight_reg <= `EQF_REG_RST;
		end else if (wr_sel[2]) begin
			chan_a_tap8_weight_reg <= WR_DATA;
		end
	end

	// Ninth and last tap of A, or of the combined filter
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			chan_a_tap9_weight_reg <= `EQF_REG_RST;
		end else if (wr_sel[3]) begin
			chan_a_tap9_weight_reg <= WR_DATA;
		end
	end

	// First tap of B; writable in either mode, used only in dual mode
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			chan_b_tap1_weight_reg <= `EQF_REG_RST;
		end else if (wr_sel[4]) begin
			chan_b_tap1_weight_reg <= WR_DATA;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------

	// Read mux; unmapped addresses return zero, so software probing
	// the gaps between words never sees a stale value
	always @* begin
		rd_data_next = `EQF_RD_IDLE;
		if (RD_EN) begin
			case (addr_sel)
				5'h01:   rd_data_next = chan_a_tap6_weight_reg;
				5'h02:   rd_data_next = chan_a_tap7_weight_reg;
				5'h04:   rd_data_next = chan_a_tap8_weight_reg;
				5'h08:   rd_data_next = chan_a_tap9_weight_reg;
				5'h10:   rd_data_next = chan_b_tap1_weight_reg;
				default: rd_data_next = `EQF_RD_IDLE;
			endcase
		end
	end

	// Data stand only in the cycle after the strobe, zero otherwise
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			rd_data_reg <= `EQF_RD_IDLE;
		end else begin
			rd_data_reg <= rd_data_next;
		end
	end

	assign RD_DATA = rd_data_reg;

	// ----------------------------------------
	// Mode tracking
	// ----------------------------------------

	// Registered so the B path switches cleanly on a clock edge; the cost is
	// one cycle of lag, and a mode change does not flush either history, so
	// software should let a few samples pass before trusting the output
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			dual_mode_reg <= 1'b0;
		end else begin
			dual_mode_reg <= ~SINGLE_CHAN_MODE;
		end
	end

	// ----------------------------------------
	// Weight vectors, tap one in the low slot
	// ----------------------------------------

	// A taps one to four come from neighbouring registers as 12-bit weights
	assign a_tap1_w = sext_w({4'h0, A_TAPS_1_4_W[11:0]});
	assign a_tap2_w = sext_w({4'h0, A_TAPS_1_4_W[23:12]});
	assign a_tap3_w = sext_w({4'h0, A_TAPS_1_4_W[35:24]});
	assign a_tap4_w = sext_w({4'h0, A_TAPS_1_4_W[47:36]});

	// The centre tap is 18 bits already and passes straight through
	assign a_tap5_w = A_CENTRE_W;

	// Taps six to nine are held here; the same four words serve the
	// combined filter in single-channel mode
	assign a_tap6_w = sext_w(chan_a_tap6_weight_reg);
	assign a_tap7_w = sext_w(chan_a_tap7_weight_reg);
	assign a_tap8_w = sext_w(chan_a_tap8_weight_reg);
	assign a_tap9_w = sext_w(chan_a_tap9_weight_reg);

	// B tap one is held here and only matters in dual-channel mode
	assign b_tap1_w = sext_w(chan_b_tap1_weight_reg);

	// B taps two to four and six to nine come from neighbouring registers
	assign b_tap2_w = sext_w({4'h0, B_TAPS_2_4_W[11:0]});
	assign b_tap3_w = sext_w({4'h0, B_TAPS_2_4_W[23:12]});
	assign b_tap4_w = sext_w({4'h0, B_TAPS_2_4_W[35:24]});
	assign b_tap6_w = sext_w({4'h0, B_TAPS_6_9_W[11:0]});
	assign b_tap7_w = sext_w({4'h0, B_TAPS_6_9_W[23:12]});
	assign b_tap8_w = sext_w({4'h0, B_TAPS_6_9_W[35:24]});
	assign b_tap9_w = sext_w({4'h0, B_TAPS_6_9_W[47:36]});

	// B centre tap, full width
	assign b_tap5_w = B_CENTRE_W;

	// A path doubles as the combined filter; tap one in the low slot
	assign coeff_a = {
		a_tap9_w,
		a_tap8_w,
		a_tap7_w,
		a_tap6_w,
		a_tap5_w,
		a_tap4_w,
		a_tap3_w,
		a_tap2_w,
		a_tap1_w
	};

	// B weights are forced to zero outside dual-channel mode, so nothing
	// left in the B history can reach the output while B is unused
	assign coeff_b = dual_mode_reg ? {
		b_tap9_w,
		b_tap8_w,
		b_tap7_w,
		b_tap6_w,
		b_tap5_w,
		b_tap4_w,
		b_tap3_w,
		b_tap2_w,
		b_tap1_w
	} : {`EQF_CVEC_W{1'b0}};

	// B samples are ignored in single-channel mode
	assign b_valid_gated = SAMPLE_B_VALID & dual_mode_reg;

	// ----------------------------------------
	// Filters
	// ----------------------------------------
	// A filter is also the combined filter; its input is then the merged stream
	eqf_fir9 u_fir_a (
		.clk          (CORE_CLK),
		.rst_n        (RST_N),
		.sample_in    (SAMPLE_A_IN),
		.sample_valid (SAMPLE_A_VALID),
		.coeff_vec    (coeff_a),
		.filt_out     (FILT_A_OUT),
		.filt_valid   (FILT_A_VALID)
	);

	// B filter sees only samples accepted in dual-channel mode
	eqf_fir9 u_fir_b (
		.clk          (CORE_CLK),
		.rst_n        (RST_N),
		.sample_in    (SAMPLE_B_IN),
		.sample_valid (b_valid_gated),
		.coeff_vec    (coeff_b),
		.filt_out     (FILT_B_OUT),
		.filt_valid   (FILT_B_VALID)
	);

endmodule

// file: tb/eqf_coeff_bank_props.sv
`include "eqf_defs.vh"

// ------
// Port checks
// ------
module eqf_coeff_bank_chk (
	input wire                   CORE_CLK,
	input wire                   RST_N,
	input wire [`EQF_ADDR_W-1:0] ADDR,
	input wire [`EQF_REG_W-1:0]  WR_DATA,
	input wire                   WR_EN,
	input wire                   RD_EN,
	input wire [`EQF_REG_W-1:0]  RD_DATA,
	input wire                   SINGLE_CHAN_MODE,
	input wire                   SAMPLE_A_VALID,
	input wire                   SAMPLE_B_VALID,
	input wire [`EQF_ACC_W-1:0]  FILT_A_OUT,
	input wire                   FILT_A_VALID,
	input wire                   FILT_B_VALID
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	// Exact decode, so neighbours of a mapped word must read back zero
	wire mapped = ADDR == `EQF_OFS_A_TAP6 || ADDR == `EQF_OFS_A_TAP7 || ADDR == `EQF_OFS_A_TAP8
		|| ADDR == `EQF_OFS_A_TAP9 || ADDR == `EQF_OFS_B_TAP1;

	// Register bus and filter timing
	chk_reset_clear: assert property (disable iff (1'b0) !RST_N |=> RD_DATA == 16'h0000 && !FILT_A_VALID)
		else $error("reset left read data or valid set");
	chk_rd_idle: assert property (!RD_EN |=> RD_DATA == 16'h0000)
		else $error("read data without a read strobe");
	chk_rd_unmapped: assert property (RD_EN && !mapped |=> RD_DATA == 16'h0000)
		else $error("unmapped read returned data");
	chk_wr_rd_back: assert property (WR_EN && mapped ##1 RD_EN && !WR_EN && $stable(ADDR)
		|=> RD_DATA == $past(WR_DATA, 2))
		else $error("write not read back");
	chk_a_latency: assert property (SAMPLE_A_VALID |=> FILT_A_VALID)
		else $error("A output valid missing");
	chk_a_no_extra: assert property (!SAMPLE_A_VALID |=> !FILT_A_VALID && $stable(FILT_A_OUT))
		else $error("A output moved without a sample");
	chk_b_single_off: assert property (SINGLE_CHAN_MODE [*2] |=> !FILT_B_VALID)
		else $error("B output in single mode");
	chk_b_dual_lat: assert property ((!SINGLE_CHAN_MODE) [*2] ##0 SAMPLE_B_VALID |=> FILT_B_VALID)
		else $error("B output valid missing");
	chk_b_no_extra: assert property (!SAMPLE_B_VALID |=> !FILT_B_VALID)
		else $error("B output valid without a sample");
endmodule

bind eqf_coeff_bank eqf_coeff_bank_chk i_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
	.WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .SINGLE_CHAN_MODE(SINGLE_CHAN_MODE),
	.SAMPLE_A_VALID(SAMPLE_A_VALID), .SAMPLE_B_VALID(SAMPLE_B_VALID), .FILT_A_OUT(FILT_A_OUT),
	.FILT_A_VALID(FILT_A_VALID), .FILT_B_VALID(FILT_B_VALID));

// file: tb/eqf_coeff_bank_tb_top.sv
`include "eqf_defs.vh"

module eqf_coeff_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic CORE_CLK = 0, RST_N = 0, WR_EN = 0, RD_EN = 0, SINGLE_CHAN_MODE = 1, SAMPLE_A_VALID = 0, SAMPLE_B_VALID = 0;
	logic [11:0] ADDR = 0, SAMPLE_A_IN = 0, SAMPLE_B_IN = 0;
	logic [15:0] WR_DATA = 0;
	wire [15:0] RD_DATA;
	wire [33:0] FILT_A_OUT, FILT_B_OUT;
	wire FILT_A_VALID, FILT_B_VALID;
	int fails = 0, checks_done = 0, cyc = 0;
	logic [11:0] addrs [5] = '{`EQF_OFS_A_TAP6, `EQF_OFS_A_TAP7, `EQF_OFS_A_TAP8, `EQF_OFS_A_TAP9, `EQF_OFS_B_TAP1};
	// Reserved bits set in some values: stored, but must not leak into the weight
	logic [15:0] vals [5] = '{16'hF806, 16'h0007, 16'hA7FF, 16'h0FFF, 16'h5123};
	longint wa [9] = '{1, -2, 3, 4, -131072, -2042, 7, 2047, -1};
	longint wb [9] = '{291, 0, 0, 0, 0, 0, 0, 0, 0};

	// ------
	// Clock, design, watchdog
	// ------
	always #2.5 CORE_CLK = ~CORE_CLK;

	eqf_coeff_bank i_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN),
		.RD_EN(RD_EN), .RD_DATA(RD_DATA), .SINGLE_CHAN_MODE(SINGLE_CHAN_MODE), .A_TAPS_1_4_W(48'h004003FFE001),
		.A_CENTRE_W(18'h20000), .B_TAPS_2_4_W(36'h0), .B_CENTRE_W(18'h0), .B_TAPS_6_9_W(48'h0),
		.SAMPLE_A_IN(SAMPLE_A_IN), .SAMPLE_A_VALID(SAMPLE_A_VALID), .SAMPLE_B_IN(SAMPLE_B_IN),
		.SAMPLE_B_VALID(SAMPLE_B_VALID), .FILT_A_OUT(FILT_A_OUT), .FILT_A_VALID(FILT_A_VALID),
		.FILT_B_OUT(FILT_B_OUT), .FILT_B_VALID(FILT_B_VALID));

	// Run needs about 70 cycles; a hang is cut well before the budget
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			results();
		end
	end

	// ------
	// Shared tasks
	// ------
	task cmp(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Both strobes set on every call, so back-to-back cycles never assign twice
	task bus(input logic we, input logic re, input logic [11:0] a, input logic [15:0] d);
		@(posedge CORE_CLK);
		WR_EN <= we;
		RD_EN <= re;
		ADDR <= a;
		WR_DATA <= d;
	endtask

	task rd(input logic [11:0] a, input logic [15:0] e);
		bus(0, 1, a, 16'h0000);
		bus(0, 0, a, 16'h0000);
		#1 cmp(RD_DATA, e);
	endtask

	// ------
	// Scenarios
	// ------
	task regs;
		for (int i = 0; i < 5; i++) rd(addrs[i], 16'h0000);
		for (int i = 0; i < 5; i++) begin
			bus(1, 0, addrs[i], vals[i]);
			rd(addrs[i], vals[i]);
		end
		bus(1, 0, 12'h424, 16'hFFFF);
		rd(12'h424, 16'h0000);
		rd(addrs[0], vals[0]);
	endtask

	// Impulse then eight zeros: each output shows one tap weight, newest tap first
	task imp(input bit b, input logic [11:0] x);
		for (int k = 0; k < 10; k++) begin
			@(posedge CORE_CLK);
			if (b) begin
				SAMPLE_B_VALID <= k < 9;
				SAMPLE_B_IN <= k == 0 ? x : 12'h000;
			end else begin
				SAMPLE_A_VALID <= k < 9;
				SAMPLE_A_IN <= k == 0 ? x : 12'h000;
			end
			#1 if (k > 0) begin
				cmp(b ? FILT_B_OUT : FILT_A_OUT, 34'($signed(x) * (b ? wb[k-1] : wa[k-1])));
				cmp({33'h0, b ? FILT_B_VALID : FILT_A_VALID}, 34'h1);
			end
		end
	endtask

	task refuse;
		@(posedge CORE_CLK);
		SINGLE_CHAN_MODE <= 1;
		repeat (2) @(posedge CORE_CLK);
		SAMPLE_B_VALID <= 1;
		SAMPLE_B_IN <= 12'h7FF;
		@(posedge CORE_CLK);
		SAMPLE_B_VALID <= 0;
		#1 cmp({33'h0, FILT_B_VALID}, 34'h0);
	endtask

	task results;
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Main sequence: single mode first, then dual for channel B
	initial begin
		repeat (3) @(posedge CORE_CLK);
		RST_N <= 1;
		regs();
		imp(0, 12'hFFD);
		@(posedge CORE_CLK);
		SINGLE_CHAN_MODE <= 0;
		imp(1, 12'h801);
		imp(0, 12'h005);
		refuse();
		results();
	end
endmodule
